// ### hw/eit_terminal_ctrl.sv
// Terminal-condition control of one extended-mode I/O channel.
// Assumes one clock, a synchronous reset, and single-cycle register strobes.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// (RULE_01) Two-bit function field selects termination; 00 is record then disconnect.
// (RULE_02) Record-disconnect input: words after count zero are discarded until record end.
// (RULE_03) Record-disconnect input: record end disconnects and idles the channel.
// (RULE_04) Record-disconnect output: count zero stops output and flags last word.
// (RULE_05) Output record end from device raises armed interrupt, then disconnects.
// (RULE_06) Device fault while connected sets the error indicator.
// (RULE_07) Function 01 transfers until count zero or record end, then disconnects.
// (RULE_08) Count-or-signal input disconnects on count zero or record end, first one.
// (RULE_09) Zero-count disconnect raises both armed interrupts, count-zero first.
// (RULE_10) Count-or-signal output disconnects after count zero and last character sent.
// (RULE_11) Count-or-signal output: early record end disconnects at once.
// (RULE_12) Function 10 transfers one record then proceeds without disconnect.
// (RULE_13) Record-proceed input: record end sets indicator, interrupt, inter-record, stays on.
// (RULE_14) Inter-record: no tape command before gap falls disconnects, no interrupt.
// (RULE_15) Inter-record: interlace use aborted until address reset and interlace reload.
// (RULE_16) Record-proceed output: last word flagged; record end gives interrupt, inter-record.
// (RULE_17) Signal-proceed: count zero raises armed interrupt, transfer continues.
// (RULE_18) Signal-proceed input: buffer overfill before reload sets rate error.
// (RULE_19) Signal-proceed input record end behaves as record-proceed.
// (RULE_20) Signal-proceed output: count zero interrupts and output keeps going.
// (RULE_21) Signal-proceed output: drained buffer with device request sets rate error.
// (RULE_22) Signal-proceed output: terminate after count zero continues as record-proceed.
// (RULE_23) Function field values 0, 2, 4, 6; value 6 is signal then proceed.
// (RULE_24) Extended bit 1 selects extended mode; 0 makes arms and function inert.
// (RULE_25) Arm bits hold for the operation; disconnect clears them.
// (RULE_26) Word count decrements per word moved and detects zero.
module eit_terminal_ctrl (
  // Clock and reset.
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  // Register port.
  input  wire logic [eit_pkg::ADDR_W-1:0]    addr,
  input  wire logic [eit_pkg::CMD_W-1:0]     wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [eit_pkg::CMD_W-1:0]     rdata,
  // Interlace and buffer side.
  input  wire logic                          word_move,
  input  wire eit_pkg::eit_dev_t             dev,
  output logic                               xfer_en,
  output logic                               discard,
  output logic                               ilv_abort,
  output logic                               dev_last,
  // Channel state.
  output logic                               ch_active,
  output logic                               dev_disconnect,
  output logic                               irq_zero_count,
  output logic                               irq_end_record
);

  typedef enum logic [2:0] {ST_IDLE, ST_XFER, ST_SKIP, ST_FINAL, ST_INTER} eit_state_t;

  eit_state_t                  state;
  eit_state_t                  next_state;
  eit_pkg::eit_cmd_t           cfg;
  logic [eit_pkg::CNT_W-1:0]   count;
  logic                        zero_hit;
  logic                        err;
  logic                        rate_err;
  logic                        eor_ind;
  logic                        inter;
  logic                        uar_ok;
  logic                        tape_hold;
  logic                        gap_q;
  logic                        disc;
  logic                        zc_req;
  logic                        er_req;
  logic                        go_inter;
  logic                        last_req;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  // Each write strobe becomes a one-cycle action on its own.
  logic cmd_wr;
  logic cnt_wr;
  logic ctl_wr;
  logic uar_cmd;
  logic top_cmd;
  logic disc_cmd;
  logic tape_cmd;
  logic out;
  logic [1:0] fn;
  logic cnt_zero;
  logic gap_fall;
  logic load_ok;

  // Short local names for the function codes.
  localparam logic [1:0] FN_RD_C = eit_pkg::FN_RD;
  localparam logic [1:0] FN_SD_C = eit_pkg::FN_SD;
  localparam logic [1:0] FN_SP_C = eit_pkg::FN_SP;

  assign cmd_wr   = wr && addr == eit_pkg::REG_CMD;
  assign cnt_wr   = wr && addr == eit_pkg::REG_COUNT;
  assign ctl_wr   = wr && addr == eit_pkg::REG_CTL;
  assign uar_cmd  = ctl_wr && wdata[eit_pkg::CTL_UAR];
  assign top_cmd  = ctl_wr && wdata[eit_pkg::CTL_TOP];
  assign disc_cmd = ctl_wr && wdata[eit_pkg::CTL_DISC];
  assign tape_cmd = ctl_wr && wdata[eit_pkg::CTL_TAPE];
  assign out      = cfg.dir_out;
  assign fn       = cfg.terminal_function_field;
  assign cnt_zero = count == '0;
  assign gap_fall = gap_q && !dev.gap;
  // In inter-record a reload only counts after the address reset.
  assign load_ok  = cnt_wr && (state != ST_INTER || uar_ok); // [RULE_15]

  ////////////////////////////////////////////////////////////////////////////
  // Word counter and interrupt ordering.

  eit_word_count #(.W(eit_pkg::CNT_W)) u_count (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .load     (load_ok),
    .load_val (wdata[eit_pkg::CNT_W-1:0]),
    .dec      (word_move && state == ST_XFER),
    .count    (count),
    .zero_hit (zero_hit)
  );

  eit_irq_order u_irq (
    .clk_sys        (clk_sys),
    .srst           (srst),
    .zc_req         (zc_req && cfg.zero_count_arm),
    .er_req         (er_req && cfg.record_end_arm),
    .irq_zero_count (irq_zero_count),
    .irq_end_record (irq_end_record)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Termination decisions.

  // A connect command wins over all; a program disconnect comes next.
  always_comb begin
    next_state = state;
    disc       = 1'b0;
    zc_req     = 1'b0;
    er_req     = 1'b0;
    go_inter   = 1'b0;
    last_req   = 1'b0;
    if (cmd_wr) begin
      next_state = ST_XFER;
    end else if (disc_cmd && state != ST_IDLE) begin
      disc = 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_XFER: begin
          if (dev.end_of_record) begin
            case (fn) // [RULE_01] [RULE_23]
              FN_RD_C: begin
                er_req = out; // [RULE_05]
                disc   = 1'b1; // [RULE_03]
              end
              FN_SD_C: disc = 1'b1; // [RULE_08] [RULE_11]
              default: begin
                er_req   = 1'b1; // [RULE_13] [RULE_19]
                go_inter = 1'b1;
              end
            endcase
          end else if (zero_hit) begin
            case (fn) // [RULE_07] [RULE_12]
              FN_SD_C: begin
                zc_req = 1'b1;
                if (out) begin
                  next_state = ST_FINAL; // [RULE_10]
                end else begin
                  er_req = 1'b1; // [RULE_09]
                  disc   = 1'b1; // [RULE_08]
                end
              end
              FN_SP_C: zc_req = 1'b1; // [RULE_17] [RULE_20]
              default: begin
                next_state = out ? ST_FINAL : ST_SKIP; // [RULE_02] [RULE_04]
                last_req   = out; // [RULE_04] [RULE_16]
              end
            endcase
          end else if (fn == FN_SP_C && out && cnt_zero && top_cmd) begin
            next_state = ST_FINAL; // [RULE_22]
            last_req   = 1'b1;
          end
        end
        ST_SKIP: begin
          if (dev.end_of_record) begin
            if (fn == FN_RD_C) begin
              disc = 1'b1; // [RULE_03]
            end else begin
              er_req   = 1'b1; // [RULE_13]
              go_inter = 1'b1;
            end
          end
        end
        ST_FINAL: begin
          if (fn == FN_SD_C) begin
            disc = dev.last_sent || dev.end_of_record; // [RULE_10]
          end else if (dev.end_of_record) begin
            er_req = 1'b1; // [RULE_05] [RULE_16]
            if (fn == FN_RD_C) begin
              disc = 1'b1; // [RULE_05]
            end else begin
              go_inter = 1'b1; // [RULE_16] [RULE_22]
            end
          end
        end
        ST_INTER: begin
          if (gap_fall && !tape_hold) begin
            disc = 1'b1; // [RULE_14]
          end else if (load_ok) begin
            next_state = ST_XFER; // [RULE_15]
          end
        end
        default: next_state = ST_IDLE;
      endcase
      if (disc) begin
        next_state = ST_IDLE;
      end else if (go_inter) begin
        next_state = ST_INTER;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command configuration.

  // Arms live for the whole operation and drop at disconnect.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg <= '0;
    end else if (cmd_wr) begin
      cfg <= eit_pkg::eit_decode(wdata); // [RULE_24]
    end else if (disc) begin
      cfg.record_end_arm <= 1'b0; // [RULE_25]
      cfg.zero_count_arm <= 1'b0; // [RULE_25]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators.

  // Connect clears the indicators, but a same-cycle fault, rate error or signal-proceed count zero still sets err, rate_err or inter.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      err      <= 1'b0;
      rate_err <= 1'b0;
      eor_ind  <= 1'b0;
      inter    <= 1'b0;
    end else begin
      if (cmd_wr) begin
        err      <= 1'b0;
        rate_err <= 1'b0;
        eor_ind  <= 1'b0;
        inter    <= 1'b0;
      end
      if (state != ST_IDLE && dev.fault) begin
        err <= 1'b1; // [RULE_06]
      end
      if (state == ST_XFER && fn == FN_SP_C && cnt_zero
          && (out ? dev.underrun : dev.overfill)) begin
        err      <= 1'b1; // [RULE_18] [RULE_21]
        rate_err <= 1'b1;
      end
      if (go_inter) begin
        eor_ind <= 1'b1; // [RULE_13]
        inter   <= 1'b1; // [RULE_16]
      end
      if (state == ST_XFER && zero_hit && fn == FN_SP_C) begin
        inter <= 1'b1;
      end
    end
  end

  // Address reset and tape hold only matter inside the inter-record state.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      uar_ok    <= 1'b0;
      tape_hold <= 1'b0;
      gap_q     <= 1'b0;
    end else begin
      gap_q <= dev.gap;
      if (next_state != ST_INTER) begin
        uar_ok    <= 1'b0;
        tape_hold <= 1'b0;
      end
      if (uar_cmd && state == ST_INTER) begin
        uar_ok <= 1'b1; // [RULE_15]
      end
      if (tape_cmd && state == ST_INTER && dev.gap) begin
        tape_hold <= 1'b1; // [RULE_14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // Outputs follow the next state so they line up with the state register.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ch_active      <= 1'b0;
      xfer_en        <= 1'b0;
      discard        <= 1'b0;
      ilv_abort      <= 1'b0;
      dev_last       <= 1'b0;
      dev_disconnect <= 1'b0;
    end else begin
      ch_active      <= next_state != ST_IDLE;
      xfer_en        <= next_state == ST_XFER;
      discard        <= next_state == ST_SKIP; // [RULE_02]
      ilv_abort      <= next_state == ST_INTER; // [RULE_15]
      dev_last       <= last_req; // [RULE_04]
      dev_disconnect <= disc;
    end
  end

  // Read data stand for exactly one cycle; unmapped reads give zero.
  always_ff @(posedge clk_sys) begin
    if (srst || !rd) begin
      rdata <= eit_pkg::DATA_RST;
    end else begin
      case (addr)
        eit_pkg::REG_STATUS: rdata <= {14'h0000, cfg, state != ST_IDLE, err,
                                       rate_err, eor_ind, inter};
        eit_pkg::REG_WCOUNT: rdata <= {10'h000, count};
        default:             rdata <= eit_pkg::DATA_RST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence quiet_s;
    !wr;
  endsequence

  sequence zc_then_er_s;
    irq_zero_count && !irq_end_record ##1 irq_end_record;
  endsequence

  rd_eor_disc_a: assert property ( // [RULE_03]
    quiet_s and (state == ST_SKIP && fn == FN_RD_C && dev.end_of_record)
    |=> dev_disconnect && !ch_active)
    else $error("record end did not disconnect");

  rd_skip_a: assert property ( // [RULE_02]
    quiet_s and (state == ST_XFER && fn == FN_RD_C && !out && zero_hit
    && !dev.end_of_record) |=> discard && !xfer_en)
    else $error("count zero did not start discard");

  rd_last_a: assert property ( // [RULE_04]
    quiet_s and (state == ST_XFER && fn == FN_RD_C && out && zero_hit
    && !dev.end_of_record) |=> dev_last ##1 !dev_last)
    else $error("last word not flagged once");

  zc_first_a: assert property ( // [RULE_09]
    quiet_s and (state == ST_XFER && fn == FN_SD_C && !out && zero_hit
    && !dev.end_of_record && cfg.record_end_arm && cfg.zero_count_arm)
    |=> zc_then_er_s)
    else $error("interrupt order wrong");

  sp_stays_a: assert property ( // [RULE_17]
    quiet_s and (state == ST_XFER && fn == FN_SP_C && zero_hit
    && !dev.end_of_record) |=> ch_active && xfer_en && !dev_disconnect)
    else $error("signal-proceed left transfer");

  rate_err_a: assert property ( // [RULE_18]
    quiet_s and (state == ST_XFER && fn == FN_SP_C && !out && cnt_zero && dev.overfill)
    |=> err && rate_err)
    else $error("rate error not set");

  gap_disc_a: assert property ( // [RULE_14]
    quiet_s and (state == ST_INTER && gap_fall && !tape_hold)
    |=> dev_disconnect ##1 !irq_end_record && !irq_zero_count)
    else $error("gap fall did not disconnect quietly");

  arm_clear_a: assert property ( // [RULE_25]
    $rose(dev_disconnect) |-> !cfg.record_end_arm && !cfg.zero_count_arm)
    else $error("arms survive disconnect");

  ext_off_a: assert property ( // [RULE_24]
    cmd_wr && !wdata[eit_pkg::CMD_EXT_BIT]
    |=> !cfg.record_end_arm && !cfg.zero_count_arm && fn == FN_RD_C)
    else $error("compatible mode kept extended controls");

  fault_err_a: assert property ( // [RULE_06]
    quiet_s and (ch_active && dev.fault) |=> err)
    else $error("fault did not set error");

endmodule

// ### pkg/eit_pkg.sv
// Constants, types and helpers for the extended I/O terminal control block.
// Assumes one 20 MHz clock and a synchronous active-high reset.
package eit_pkg;

  // Widths of the command word, the word count and the register address.
  localparam int CMD_W  = 25;
  localparam int CNT_W  = 15;
  localparam int ADDR_W = 3;

  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] REG_CMD    = 3'h0;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 3'h1;
  localparam logic [ADDR_W-1:0] REG_CTL    = 3'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] REG_WCOUNT = 3'h4;

  // Command bit n sits at index 23-n; bit 24 carries the direction.
  localparam int CMD_DIR_BIT = 24;
  localparam int CMD_EXT_BIT = 11;
  localparam int CMD_ER_BIT  = 10;
  localparam int CMD_ZC_BIT  = 9;
  localparam int CMD_FN_LO   = 7;

  // Control register bits, each a one-cycle action.
  localparam int CTL_UAR  = 0;
  localparam int CTL_TOP  = 1;
  localparam int CTL_DISC = 2;
  localparam int CTL_TAPE = 3;

  // Terminal function codes (octal 0, 2, 4, 6 in the command word).
  localparam logic [1:0] FN_RD = 2'h0;
  localparam logic [1:0] FN_SD = 2'h1;
  localparam logic [1:0] FN_RP = 2'h2;
  localparam logic [1:0] FN_SP = 2'h3;

  // Reset values.
  localparam logic [CNT_W-1:0] CNT_RST  = 15'h0000;
  localparam logic [CMD_W-1:0] DATA_RST = 25'h0000000;

  // Decoded command fields.
  typedef struct packed {
    logic       dir_out;
    logic       ext;
    logic       record_end_arm;
    logic       zero_count_arm;
    logic [1:0] terminal_function_field;
  } eit_cmd_t;

  // Signals from the buffer side and the peripheral.
  typedef struct packed {
    logic end_of_record;
    logic gap;
    logic fault;
    logic overfill;
    logic underrun;
    logic last_sent;
  } eit_dev_t;

  // With the extended bit clear the arms and function are ignored.
  function automatic eit_cmd_t eit_decode(input logic [CMD_W-1:0] w);
    eit_cmd_t c;
    c.dir_out                 = w[CMD_DIR_BIT];
    c.ext                     = w[CMD_EXT_BIT];
    c.record_end_arm          = w[CMD_EXT_BIT] & w[CMD_ER_BIT];
    c.zero_count_arm          = w[CMD_EXT_BIT] & w[CMD_ZC_BIT];
    c.terminal_function_field = w[CMD_EXT_BIT] ? w[CMD_FN_LO+1:CMD_FN_LO] : FN_RD;
    return c;
  endfunction

endpackage

// ### hw/eit_word_count.sv
// Channel word counter with a zero-reached pulse.
// Assumes load and decrement never come in the same cycle from one source.
`timescale 1ns/1ps
module eit_word_count #(
  parameter int W = 15
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // Control.
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  // State.
  output logic      [W-1:0] count,
  output logic              zero_hit
);

  // A load wins over a move; a move at zero is not counted.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count    <= W'(eit_pkg::CNT_RST);
      zero_hit <= 1'b0;
    end else begin
      zero_hit <= 1'b0;
      if (load) begin
        count <= load_val;
      end else if (dec && count != '0) begin
        count    <= count - 1'b1; // [RULE_26]
        zero_hit <= (count == W'(1)); // [RULE_26]
      end
    end
  end

endmodule

// ### hw/eit_irq_order.sv
// Orders the count-zero and end-of-record interrupt pulses.
// Assumes both requests are already gated by their arm bits.
`timescale 1ns/1ps
module eit_irq_order (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic srst,
  // Requests.
  input  wire logic zc_req,
  input  wire logic er_req,
  // Interrupt pulses.
  output logic      irq_zero_count,
  output logic      irq_end_record
);

  logic pend_er;

  // When both come together the count-zero pulse goes one cycle ahead.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_zero_count <= 1'b0;
      irq_end_record <= 1'b0;
      pend_er        <= 1'b0;
    end else begin
      irq_zero_count <= zc_req;
      pend_er        <= zc_req & er_req; // [RULE_09]
      irq_end_record <= (er_req & ~zc_req) | pend_er; // [RULE_09]
    end
  end

endmodule

// ### verif/eit_periph_model.sv
// Behavioural peripheral on the far side of the channel buffer.
// Assumes the bench asks for single-cycle events through req.
`timescale 1ns/1ps
module eit_periph_model #(
  parameter int RESP_DLY = 4,
  parameter int GAP_CYC  = 20
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // Channel side.
  input  wire logic              dev_last,
  output eit_pkg::eit_dev_t      dev,
  // Bench control.
  input  wire eit_pkg::eit_dev_t req,
  input  wire logic              tape
);
  int  resp_cnt;
  int  gap_cnt;
  logic rec_now;

  ////////////////////////////////////////////////////////////////////////////////
  // A record end comes from the bench or as the answer to a flagged last word.
  assign rec_now = req.end_of_record | (resp_cnt == 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Events and the tape gap; the gap stays up a fixed time so a late command misses it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dev      <= '0;
      resp_cnt <= 0;
      gap_cnt  <= 0;
    end else begin
      dev.fault         <= req.fault;
      dev.overfill      <= req.overfill;
      dev.underrun      <= req.underrun;
      dev.last_sent     <= req.last_sent | (resp_cnt == 1);
      dev.end_of_record <= rec_now;
      resp_cnt          <= dev_last ? RESP_DLY : (resp_cnt > 0 ? resp_cnt - 1 : 0);
      gap_cnt           <= (tape & rec_now) ? GAP_CYC : (gap_cnt > 0 ? gap_cnt - 1 : 0);
      dev.gap           <= (tape & rec_now) | (gap_cnt > 1);
    end
  end
endmodule

// ### verif/tb.sv
// Bench that drives the terminal control block through its register port.
// Assumes the peripheral model answers a flagged last word after RESP cycles.
`timescale 1ns/1ps
module tb;
  localparam int                RESP  = 4;
  localparam logic [2:0]        ST    = eit_pkg::REG_STATUS;
  localparam logic [2:0]        CTL   = eit_pkg::REG_CTL;
  localparam eit_pkg::eit_dev_t E_REC = 6'h20;
  localparam eit_pkg::eit_dev_t E_FLT = 6'h08;
  localparam eit_pkg::eit_dev_t E_OVF = 6'h04;
  localparam eit_pkg::eit_dev_t E_URN = 6'h02;
  localparam eit_pkg::eit_dev_t E_SNT = 6'h01;
  logic                         clk_sys, srst, wr, rd, word_move, tape;
  logic [2:0]                   addr;
  logic [24:0]                  wdata, rdata, v;
  logic                         xfer_en, discard, ilv_abort, dev_last, ch_active;
  logic                         dev_disconnect, irq_zero_count, irq_end_record;
  eit_pkg::eit_dev_t            dev, req;
  int                           n_fail = 0, total_checks = 0, cyc = 0;
  int                           n_zc = 0, n_er = 0, n_dl = 0, t_zc = 0, t_er = 0, n_dc = 0;
  int                           s_zc, s_er, s_dl, s_dc;

  eit_terminal_ctrl i_eit_terminal_ctrl (.clk_sys(clk_sys), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .word_move(word_move), .dev(dev),
    .xfer_en(xfer_en), .discard(discard), .ilv_abort(ilv_abort), .dev_last(dev_last),
    .ch_active(ch_active), .dev_disconnect(dev_disconnect),
    .irq_zero_count(irq_zero_count), .irq_end_record(irq_end_record));
  eit_periph_model #(.RESP_DLY(RESP), .GAP_CYC(20)) i_eit_periph_model (.clk_sys(clk_sys),
    .srst(srst), .dev_last(dev_last), .dev(dev), .req(req), .tape(tape));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 50 ns period.
  always #25 clk_sys = ~clk_sys;

  // Pulses are counted here, as a one-cycle output is easy to miss.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (irq_zero_count === 1'b1) begin
      n_zc <= n_zc + 1;
      t_zc <= cyc;
    end
    if (irq_end_record === 1'b1) begin
      n_er <= n_er + 1;
      t_er <= cyc;
    end
    if (dev_last === 1'b1) n_dl <= n_dl + 1;
    if (dev_disconnect === 1'b1) n_dc <= n_dc + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, bus and event tasks.
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", w, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [24:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic ev(input eit_pkg::eit_dev_t e);
    @(posedge clk_sys);
    req <= e;
    @(posedge clk_sys);
    req <= '0;
  endtask
  task automatic moves(input int n);
    @(posedge clk_sys);
    word_move <= 1'b1;
    repeat (n) @(posedge clk_sys);
    word_move <= 1'b0;
  endtask
  task automatic start(input logic [3:0] m, input logic [1:0] f, input logic [14:0] n);
    wr_reg(eit_pkg::REG_CMD, {m[3], 12'h000, m[2:0], f, 7'h00});
    wr_reg(eit_pkg::REG_COUNT, 25'(n));
    s_zc = n_zc;
    s_er = n_er;
    s_dl = n_dl;
    s_dc = n_dc;
  endtask
  task automatic fin(input string name);
    wr_reg(CTL, 25'h4);
    tick(2);
    $display("test %s done", name);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    print_verdict;
  end

  // Main sequence.
  initial begin
    clk_sys   = 1'b0;
    srst      = 1'b1;
    wr        = 1'b0;
    rd        = 1'b0;
    word_move = 1'b0;
    tape      = 1'b0;
    addr      = '0;
    wdata     = '0;
    req       = '0;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    rd_reg(ST);
    check("status", v, 0);
    rd_reg(3'h6);
    check("unmapped", v, 0);
    for (int f = 0; f < 4; f++) begin
      start(4'h7, f[1:0], 15'h5);
      rd_reg(ST);
      check("fields", v[10:5], {4'h7, f[1:0]});
      wr_reg(CTL, 25'h4);
    end
    start(4'h3, eit_pkg::FN_SP, 15'h5);
    rd_reg(ST);
    check("compat", v[9:5], 0);
    fin("modes");
    start(4'h6, eit_pkg::FN_RD, 15'h3);
    moves(3);
    tick(3);
    check("discard", discard, 1);
    ev(E_FLT);
    tick(2);
    rd_reg(ST);
    check("error", v[3:2], 2);
    ev(E_REC);
    tick(2);
    check("active", ch_active, 0);
    rd_reg(ST);
    check("arms", v[8:7], 0);
    fin("record_input");
    start(4'h7, eit_pkg::FN_SD, 15'h2);
    moves(2);
    tick(6);
    check("active", ch_active, 0);
    check("irq_zc", n_zc - s_zc, 1);
    check("irq_er", n_er - s_er, 1);
    check("irq_order", t_er - t_zc, 1);
    start(4'hC, eit_pkg::FN_SD, 15'h4);
    moves(1);
    ev(E_REC);
    tick(2);
    check("active", ch_active, 0);
    start(4'hC, eit_pkg::FN_SD, 15'h1);
    moves(1);
    tick(4);
    check("active", ch_active, 1);
    ev(E_SNT);
    tick(2);
    check("active", ch_active, 0);
    fin("signal_disconnect");
    start(4'hE, eit_pkg::FN_RD, 15'h2);
    moves(2);
    tick(3);
    check("last", n_dl - s_dl, 1);
    check("xfer", xfer_en, 0);
    tick(RESP + 4);
    check("irq_er", n_er - s_er, 1);
    check("active", ch_active, 0);
    fin("record_output");
    tape <= 1'b1;
    start(4'h6, eit_pkg::FN_RP, 15'h1);
    moves(1);
    tick(3);
    moves(1);
    rd_reg(eit_pkg::REG_WCOUNT);
    check("count", v[14:0], 0);
    check("discard", discard, 1);
    ev(E_REC);
    tick(3);
    check("active", ch_active, 1);
    check("abort", ilv_abort, 1);
    check("irq_er", n_er - s_er, 1);
    rd_reg(ST);
    check("indicators", v[1:0], 3);
    s_er = n_er;
    for (int i = 0; i < 40 && ch_active === 1'b1; i++) tick(1);
    tick(2);
    check("active", ch_active, 0);
    check("irq_gap", n_er - s_er + n_zc - s_zc, 0);
    check("disc", n_dc - s_dc, 1);
    tape <= 1'b0;
    fin("record_proceed_input");
    start(4'hE, eit_pkg::FN_RP, 15'h1);
    moves(1);
    tick(RESP + 8);
    check("last", n_dl - s_dl, 1);
    check("irq_er", n_er - s_er, 1);
    check("active", ch_active, 1);
    wr_reg(eit_pkg::REG_COUNT, 25'h3);
    rd_reg(eit_pkg::REG_WCOUNT);
    check("count", v[14:0], 0);
    wr_reg(CTL, 25'h1);
    wr_reg(eit_pkg::REG_COUNT, 25'h3);
    tick(2);
    check("abort", ilv_abort, 0);
    check("xfer", xfer_en, 1);
    fin("record_proceed_output");
    start(4'hD, eit_pkg::FN_SP, 15'h1);
    moves(1);
    tick(4);
    check("irq_zc", n_zc - s_zc, 1);
    check("xfer", xfer_en, 1);
    check("last", n_dl - s_dl, 0);
    ev(E_URN);
    tick(2);
    rd_reg(ST);
    check("rate", v[3:2], 3);
    wr_reg(CTL, 25'h2);
    tick(RESP + 8);
    check("last", n_dl - s_dl, 1);
    check("active", ch_active, 1);
    fin("signal_proceed_output");
    start(4'h5, eit_pkg::FN_SP, 15'h1);
    moves(1);
    tick(4);
    check("irq_zc", n_zc - s_zc, 1);
    check("active", ch_active, 1);
    ev(E_OVF);
    tick(2);
    rd_reg(ST);
    check("rate", v[3:2], 3);
    ev(E_REC);
    tick(3);
    check("abort", ilv_abort, 1);
    fin("signal_proceed_input");
    print_verdict;
  end
endmodule
